// *** core/ffs_pkg.sv ***
// package: constants, register map and carriers for the flash fault status flags
package ffs_pkg;

  // register offsets on the module register port
  localparam logic [7:0] FFS_OFS_CFG = 8'h04;
  localparam logic [7:0] FFS_OFS_CMD_STATUS = 8'h06;
  localparam logic [7:0] FFS_OFS_ERR_STATUS = 8'h07;
  localparam logic [7:0] FFS_OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] FFS_OFS_INT_MASK = 8'h09;

  // command status field positions
  localparam int FFS_CS_COMPLETE_BIT = 7;
  localparam int FFS_CS_BUSY_BIT = 3;
  localparam int FFS_CS_RESERVED_BIT_BIT = 2;
  localparam int FFS_CS_ERR_LSB = 0;

  // configuration and error status field positions
  localparam int FFS_CFG_IGNORE_SF_BIT = 4;
  localparam int FFS_ES_SF_BIT = 0;
  localparam int FFS_ES_DF_BIT = 1;

  // interrupt status and mask layout
  localparam int FFS_IRQ_W = 4;
  localparam int FFS_IRQ_DONE_BIT = 0;
  localparam int FFS_IRQ_CMDERR_BIT = 1;
  localparam int FFS_IRQ_SF_BIT = 2;
  localparam int FFS_IRQ_DF_BIT = 3;

  // reset values
  localparam logic [1:0] FFS_RST_ERR_FIELD = 2'h0;
  localparam logic [1:0] FFS_RST_FAULTS = 2'h0;
  localparam logic [FFS_IRQ_W-1:0] FFS_RST_INT_MASK = 4'h0;
  localparam logic [7:0] FFS_RST_RDATA = 8'h00;

  // register port request, one strobe per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ffs_bus_req_t;

  // one flash array read finishing, with its ecc verdict
  typedef struct packed {
    logic valid;
    logic single;
    logic dbl;
    logic collide;
  } ffs_rd_evt_t;

  // command sequencer view
  typedef struct packed {
    logic busy;
    logic start;
    logic err_valid;
    logic [1:0] err_code;
  } ffs_cmd_t;

endpackage : ffs_pkg

// *** core/ffs_sticky.sv ***
// sticky flag bank: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ffs_sticky
  import ffs_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] flags_out
);

  // whole state of the bank
  logic [W-1:0] state;
  logic [W-1:0] next_state;

  // a set in the clearing cycle is kept
  always_comb begin
    next_state = (state & ~clr_in) | set_in;
  end

  // register the copy
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags_out = state;

endmodule : ffs_sticky
`default_nettype wire

// *** core/ffs_flags.sv ***
// flash controller status flags, error status and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module ffs_flags
  import ffs_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ffs_bus_req_t bus_in,
  output logic [7:0] rdata_out,
  input wire ffs_rd_evt_t rd_evt_in,
  input wire ffs_cmd_t cmd_in,
  input wire logic [1:0] reset_seq_err_in,
  output logic busy_out,
  output logic ignore_sf_out,
  output logic irq_out
);

  // registered state of this module, apart from the fault and interrupt flag banks
  typedef struct packed {
    logic busy;
    logic init_done;
    logic ignore_sf;
    logic [1:0] err_field;
    logic [FFS_IRQ_W-1:0] int_mask;
    logic [7:0] rdata;
  } ffs_state_t;

  ffs_state_t st; // current state
  ffs_state_t next_st; // next state

  logic [1:0] fault_flags; // error status flags, sf in bit 0
  logic [1:0] fault_set; // fault set requests
  logic [1:0] fault_clr; // write-one clears
  logic [FFS_IRQ_W-1:0] int_status; // sticky interrupt causes
  logic [FFS_IRQ_W-1:0] int_set; // interrupt cause events
  logic [FFS_IRQ_W-1:0] int_clr; // read clears
  logic wr_err; // write to error status
  logic rd_int; // read of interrupt status
  logic ecc_dbl; // genuine two-bit error
  logic ecc_sgl; // genuine corrected error
  logic done_evt; // command just finished
  logic [7:0] cmd_status; // composed command status byte

  // decode strobes once
  assign wr_err = bus_in.wr && (bus_in.addr == FFS_OFS_ERR_STATUS);
  assign rd_int = bus_in.rd && (bus_in.addr == FFS_OFS_INT_STATUS);

  // fault classification
  always_comb begin
    // a double verdict outranks a single one for parity errors
    ecc_dbl = rd_evt_in.valid && rd_evt_in.dbl;
    ecc_sgl = rd_evt_in.valid && rd_evt_in.single && !rd_evt_in.dbl;
    fault_set = '0;
    // with sf not ignored, collision raises both and ecc error exactly one
    fault_set[FFS_ES_DF_BIT] = ecc_dbl || (rd_evt_in.valid && rd_evt_in.collide);
    // ignore bit silences the single flag, collisions included
    fault_set[FFS_ES_SF_BIT] = !st.ignore_sf
        && (ecc_sgl || (rd_evt_in.valid && rd_evt_in.collide));
    fault_clr = '0;
    // only ones written clear, zeros leave the flag
    if (wr_err) begin
      fault_clr[FFS_ES_DF_BIT] = bus_in.wdata[FFS_ES_DF_BIT];
      fault_clr[FFS_ES_SF_BIT] = bus_in.wdata[FFS_ES_SF_BIT];
    end
  end

  // fault flags live one register stage behind the read event
  ffs_sticky #(
    .W(2)
  ) u_faults (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in(fault_set),
    .clr_in(fault_clr),
    .flags_out(fault_flags)
  );

  // completion seen as the busy level falling
  assign done_evt = st.busy && !cmd_in.busy;

  // interrupt causes
  always_comb begin
    int_set = '0;
    int_set[FFS_IRQ_DONE_BIT] = done_evt;
    int_set[FFS_IRQ_CMDERR_BIT] = cmd_in.err_valid && (cmd_in.err_code != 2'h0);
    int_set[FFS_IRQ_SF_BIT] = fault_set[FFS_ES_SF_BIT];
    int_set[FFS_IRQ_DF_BIT] = fault_set[FFS_ES_DF_BIT];
    // a read takes all causes away, a new one in that cycle stays
    int_clr = rd_int ? {FFS_IRQ_W{1'b1}} : '0;
  end

  ffs_sticky #(
    .W(FFS_IRQ_W)
  ) u_irq (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .set_in(int_set),
    .clr_in(int_clr),
    .flags_out(int_status)
  );

  // command status byte as software sees it
  always_comb begin
    cmd_status = 8'h00;
    cmd_status[FFS_CS_COMPLETE_BIT] = !st.busy;
    cmd_status[FFS_CS_BUSY_BIT] = st.busy;
    cmd_status[FFS_CS_RESERVED_BIT_BIT] = 1'b0;
    cmd_status[FFS_CS_ERR_LSB +: 2] = st.err_field;
  end

  // next state
  always_comb begin
    next_st = st;
    // busy mirrors the sequencer, complete is its inverse
    next_st.busy = cmd_in.busy;
    // reset sequence outcome is caught once, after release
    if (!st.init_done) begin
      next_st.init_done = 1'b1;
      next_st.err_field = reset_seq_err_in;
    end else if (cmd_in.start) begin
      // a new command starts with a clean error field
      next_st.err_field = FFS_RST_ERR_FIELD;
    end
    // errors accumulate, start and error together keep the error
    if (st.init_done && cmd_in.err_valid) begin
      next_st.err_field = next_st.err_field | cmd_in.err_code;
    end
    // register writes
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        FFS_OFS_CFG: begin
          next_st.ignore_sf = bus_in.wdata[FFS_CFG_IGNORE_SF_BIT];
        end
        FFS_OFS_INT_MASK: begin
          next_st.int_mask = bus_in.wdata[FFS_IRQ_W-1:0];
        end
        default: begin
          // status registers are handled elsewhere or read-only
        end
      endcase
    end
    // read data stands only in the cycle after the strobe
    next_st.rdata = FFS_RST_RDATA;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        FFS_OFS_CFG: begin
          next_st.rdata[FFS_CFG_IGNORE_SF_BIT] = st.ignore_sf;
        end
        FFS_OFS_CMD_STATUS: begin
          next_st.rdata = cmd_status;
        end
        FFS_OFS_ERR_STATUS: begin
          next_st.rdata[1:0] = fault_flags;
        end
        FFS_OFS_INT_STATUS: begin
          next_st.rdata[FFS_IRQ_W-1:0] = int_status;
        end
        FFS_OFS_INT_MASK: begin
          next_st.rdata[FFS_IRQ_W-1:0] = st.int_mask;
        end
        default: begin
          // unmapped reads answer zero
          next_st.rdata = FFS_RST_RDATA;
        end
      endcase
    end
  end

  // register the copy
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st.busy <= 1'b0;
      st.init_done <= 1'b0;
      st.ignore_sf <= 1'b0;
      st.err_field <= FFS_RST_ERR_FIELD;
      st.int_mask <= FFS_RST_INT_MASK;
      st.rdata <= FFS_RST_RDATA;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign rdata_out = st.rdata;
  assign busy_out = st.busy;
  assign ignore_sf_out = st.ignore_sf;
  // level request while any unmasked cause is pending
  assign irq_out = |(int_status & st.int_mask);

  // software must leave a gap after a flash read; flags lag one cycle

  // checks, all on the bus clock and quiet during reset except a_reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  property p_busy_follows;
    ##1 busy_out == $past(cmd_in.busy);
  endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("busy flag lags wrong");

  property p_reserved_bit_zero;
    (bus_in.rd && bus_in.addr == FFS_OFS_CMD_STATUS)
        |=> !rdata_out[FFS_CS_RESERVED_BIT_BIT] && (rdata_out[FFS_CS_BUSY_BIT] == $past(busy_out));
  endproperty
  a_reserved_bit_zero: assert property (p_reserved_bit_zero) else $error("status read wrong");

  property p_err_set;
    (st.init_done && cmd_in.err_valid && !cmd_in.start)
        |=> (st.err_field & $past(cmd_in.err_code)) == $past(cmd_in.err_code);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error field missed");

  property p_dbl_set;
    (rd_evt_in.valid && (rd_evt_in.dbl || rd_evt_in.collide)) |=> fault_flags[FFS_ES_DF_BIT];
  endproperty
  a_dbl_set: assert property (p_dbl_set) else $error("double fault not stored");

  property p_dbl_zero_write;
    (wr_err && !bus_in.wdata[FFS_ES_DF_BIT] && !fault_set[FFS_ES_DF_BIT])
        |=> fault_flags[FFS_ES_DF_BIT] == $past(fault_flags[FFS_ES_DF_BIT]);
  endproperty
  a_dbl_zero_write: assert property (p_dbl_zero_write) else $error("zero write changed df");

  property p_ignore_sf;
    (st.ignore_sf && !fault_flags[FFS_ES_SF_BIT]) |=> !fault_flags[FFS_ES_SF_BIT];
  endproperty
  a_ignore_sf: assert property (p_ignore_sf) else $error("sf set while ignored");

  property p_sf_clear;
    (wr_err && bus_in.wdata[FFS_ES_SF_BIT] && !fault_set[FFS_ES_SF_BIT])
        |=> !fault_flags[FFS_ES_SF_BIT];
  endproperty
  a_sf_clear: assert property (p_sf_clear) else $error("sf not cleared by one");

  property p_excl;
    (rd_evt_in.valid && !rd_evt_in.collide && fault_flags == 2'h0 && !wr_err
        && (rd_evt_in.single || rd_evt_in.dbl)) |=> fault_flags != 2'h3;
  endproperty
  a_excl: assert property (p_excl) else $error("parity error gave both flags");

  property p_collide;
    (rd_evt_in.valid && rd_evt_in.collide && !st.ignore_sf) |=> fault_flags == 2'h3;
  endproperty
  a_collide: assert property (p_collide) else $error("collision not both flags");

  property p_one_cycle;
    (rd_evt_in.valid && rd_evt_in.dbl && !fault_flags[FFS_ES_DF_BIT])
        |-> !fault_flags[FFS_ES_DF_BIT] ##1 fault_flags[FFS_ES_DF_BIT];
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("fault capture timing wrong");

  property p_err_read;
    (bus_in.rd && bus_in.addr == FFS_OFS_ERR_STATUS)
        |=> rdata_out == {6'h00, $past(fault_flags)};
  endproperty
  a_err_read: assert property (p_err_read) else $error("error status read wrong");

  property p_irq_done;
    (done_evt && st.int_mask[FFS_IRQ_DONE_BIT] && !bus_in.wr) |=> irq_out;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("no irq on completion");

  property p_reset;
    @(posedge clk_in) disable iff (1'b0)
      srst_in |=> fault_flags == FFS_RST_FAULTS && !busy_out && !irq_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state");

  // first cycle after release loads the reset sequence verdict
  property p_err_init;
    !st.init_done |=> st.err_field == $past(reset_seq_err_in);
  endproperty
  a_err_init: assert property (p_err_init) else $error("reset sequence error lost");

  // a zero error code must not raise the command error cause
  property p_cmderr_quiet;
    (!int_status[FFS_IRQ_CMDERR_BIT] && !(cmd_in.err_valid && cmd_in.err_code != 2'h0))
        |=> !int_status[FFS_IRQ_CMDERR_BIT];
  endproperty
  a_cmderr_quiet: assert property (p_cmderr_quiet) else $error("bogus error cause");

  // configuration write lands in the ignore bit next cycle
  property p_cfg_write;
    (bus_in.wr && bus_in.addr == FFS_OFS_CFG)
        |=> ignore_sf_out == $past(bus_in.wdata[FFS_CFG_IGNORE_SF_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("ignore bit not taken");

  property p_cov_collide;
    rd_evt_in.valid && rd_evt_in.collide ##1 fault_flags == 2'h3;
  endproperty
  c_collide: cover property (p_cov_collide);

  property p_cov_clear;
    fault_flags[FFS_ES_DF_BIT] ##1 wr_err ##1 !fault_flags[FFS_ES_DF_BIT];
  endproperty
  c_clear: cover property (p_cov_clear);

  property p_cov_irq;
    done_evt ##1 irq_out ##1 rd_int;
  endproperty
  c_irq: cover property (p_cov_irq);

  property p_cov_ignored;
    st.ignore_sf && rd_evt_in.valid && rd_evt_in.collide ##1 fault_flags == 2'h2;
  endproperty
  c_ignored: cover property (p_cov_ignored);

endmodule : ffs_flags
`default_nettype wire

// *** verif/ffs_flash_model.sv ***
// behavioural flash array and command sequencer facing the status flags
`timescale 1ns/1ps
`default_nettype none
module ffs_flash_model
  import ffs_pkg::*;
#(
  parameter int CMD_CYCLES = 10,
  parameter logic [1:0] RESET_ERR = 2'h2
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ffs_rd_evt_t rd_req_in,
  input wire logic go_in,
  input wire logic [1:0] err_in,
  output ffs_rd_evt_t rd_evt_out,
  output ffs_cmd_t cmd_out,
  output logic [1:0] reset_seq_err_out
);
  // cycles left in the running command
  logic [7:0] left;

  // reset sequence verdict held as a level
  assign reset_seq_err_out = RESET_ERR;

  // reads finish one cycle after request; sequencer counts down
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      left <= 8'h00;
      rd_evt_out <= '0;
      cmd_out <= '0;
    end else begin
      rd_evt_out <= rd_req_in;
      // a read on the block under command returns invalid data
      rd_evt_out.collide <= rd_req_in.collide | (rd_req_in.valid & cmd_out.busy);
      cmd_out.start <= go_in;
      cmd_out.err_valid <= 1'b0;
      cmd_out.err_code <= err_in;
      if (go_in) begin
        left <= 8'(CMD_CYCLES);
        cmd_out.busy <= 1'b1;
      end else if (left == 8'h01) begin
        // verdict reported as the command ends
        left <= 8'h00;
        cmd_out.busy <= 1'b0;
        cmd_out.err_valid <= 1'b1;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule // ffs_flash_model
`default_nettype wire

// *** verif/ffs_flags_bench.sv ***
// self-checking bench for the flash fault status flags
`timescale 1ns/1ps
`default_nettype none
module ffs_flags_bench
  import ffs_pkg::*;
;
  logic clk_in = 1'b0; // 40 MHz
  logic srst_in = 1'b1;
  ffs_bus_req_t bus = '0; // register port master
  ffs_rd_evt_t req = '0; // flash read request
  logic go = 1'b0; // command launch
  logic [1:0] err = 2'h0; // command verdict
  ffs_rd_evt_t evt;
  ffs_cmd_t cmd;
  logic [1:0] rst_err;
  logic [7:0] rdata_out;
  logic busy_out;
  logic ignore_sf_out;
  logic irq_out;
  int fails = 0;
  int compares = 0;

  // clock, half period 12.5 ns
  always #12.5 clk_in = ~clk_in;

  ffs_flash_model ffs_flash_model_i (.clk_in(clk_in), .srst_in(srst_in), .rd_req_in(req),
    .go_in(go), .err_in(err), .rd_evt_out(evt), .cmd_out(cmd), .reset_seq_err_out(rst_err));

  ffs_flags ffs_flags_i (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus),
    .rdata_out(rdata_out), .rd_evt_in(evt), .cmd_in(cmd), .reset_seq_err_in(rst_err),
    .busy_out(busy_out), .ignore_sf_out(ignore_sf_out), .irq_out(irq_out));

  // one comparison, counted
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 check(rdata_out, exp);
  endtask

  // flash array read, then the cpu idles before looking
  task automatic fread(input logic s, input logic d, input logic c);
    @(posedge clk_in);
    req <= '{1'b1, s, d, c};
    @(posedge clk_in);
    req <= '0;
    repeat (2) @(posedge clk_in);
  endtask

  // the only verdict
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one command launch with its final verdict code
  task automatic launch(input logic [1:0] e);
    @(posedge clk_in);
    go <= 1'b1;
    err <= e;
    @(posedge clk_in);
    go <= 1'b0;
  endtask

  // bounded wait for the sequencer to go idle
  task automatic idle_wait;
    for (int i = 0; i < 50 && busy_out !== 1'b0; i++) @(posedge clk_in);
    if (busy_out !== 1'b0) begin
      fails++;
      $display("[ERR] %0t busy never fell", $time);
      close_out;
    end
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    close_out;
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(FFS_OFS_CMD_STATUS, 8'h82);
    rd(FFS_OFS_ERR_STATUS, 8'h00);
    rd(8'h3F, 8'h00);
    wr(FFS_OFS_INT_MASK, 8'h0F);
    rd(FFS_OFS_INT_MASK, 8'h0F);
    // corrected single fault, then write zero and write one
    fread(1'b1, 1'b0, 1'b0);
    rd(FFS_OFS_ERR_STATUS, 8'h01);
    #1 check({7'h00, irq_out}, 8'h01);
    wr(FFS_OFS_ERR_STATUS, 8'h00);
    rd(FFS_OFS_ERR_STATUS, 8'h01);
    wr(FFS_OFS_ERR_STATUS, 8'h01);
    rd(FFS_OFS_ERR_STATUS, 8'h00);
    // uncorrectable fault; clearing the wrong bit leaves it
    fread(1'b0, 1'b1, 1'b0);
    rd(FFS_OFS_ERR_STATUS, 8'h02);
    wr(FFS_OFS_ERR_STATUS, 8'h01);
    rd(FFS_OFS_ERR_STATUS, 8'h02);
    wr(FFS_OFS_ERR_STATUS, 8'h02);
    rd(FFS_OFS_ERR_STATUS, 8'h00);
    // both verdicts from the ecc: double wins
    fread(1'b1, 1'b1, 1'b0);
    rd(FFS_OFS_ERR_STATUS, 8'h02);
    wr(FFS_OFS_ERR_STATUS, 8'h03);
    // command ending in error, with a colliding read inside it
    launch(2'h1);
    fread(1'b0, 1'b0, 1'b0);
    rd(FFS_OFS_CMD_STATUS, 8'h08);
    rd(FFS_OFS_ERR_STATUS, 8'h03);
    idle_wait;
    rd(FFS_OFS_CMD_STATUS, 8'h81);
    rd(FFS_OFS_INT_STATUS, 8'h0F);
    #1 check({7'h00, irq_out}, 8'h00);
    wr(FFS_OFS_ERR_STATUS, 8'h03);
    // single faults ignored by configuration
    wr(FFS_OFS_CFG, 8'h10);
    rd(FFS_OFS_CFG, 8'h10);
    #1 check({7'h00, ignore_sf_out}, 8'h01);
    fread(1'b1, 1'b0, 1'b0);
    rd(FFS_OFS_ERR_STATUS, 8'h00);
    // clean command; a colliding read while ignoring gives df only
    launch(2'h0);
    fread(1'b0, 1'b0, 1'b0);
    rd(FFS_OFS_ERR_STATUS, 8'h02);
    idle_wait;
    rd(FFS_OFS_CMD_STATUS, 8'h80);
    rd(FFS_OFS_INT_STATUS, 8'h09);
    // reset in mid-run with a double fault still pending
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(FFS_OFS_ERR_STATUS, 8'h00);
    rd(FFS_OFS_CMD_STATUS, 8'h82);
    #1 check({6'h00, ignore_sf_out, irq_out}, 8'h00);
    close_out;
  end
endmodule // ffs_flags_bench
`default_nettype wire
